// ---- src/hoc_control.v ----
// host operating control register with state, enables and routing
// Overview of operation
// - register sits at byte offset 04h and reads zero after hardware reset
// - only state field changes without a software write or reset
// - wake-up enable plus resume-detected status signals remote wake-up
// - wake-up enable does not affect interrupt generation
// - wake-up-connected cleared by hardware reset, kept on software reset
// - routing bit clear uses bus interrupt, set uses management interrupt
// - routing bit cleared by hardware reset, kept on software reset
// - state field 7:6: 00 reset, 01 resume, 10 operational, 11 suspend
// - entering operational starts frame generation 1 ms later
// - hardware changes state only in suspend, moving to resume on resume
// - software reset gives suspend; hardware reset gives reset state
// - bulk enable takes effect at next frame start
// - control enable takes effect at next frame start
// - periodic enable takes effect at next frame start
// - isochronous disabled stops periodic list at first isochronous item
// - ratio field gives one to four control items per bulk item
`timescale 1ns/1ns
`include "hoc_map.vh"
module hoc_control #(
  parameter SOF_DELAY_CYC = `HOC_SOF_DELAY_CYC
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        soft_reset_in,
  input  wire        wr_en_in,
  input  wire        rd_en_in,
  input  wire [7:0]  addr_in,
  input  wire [31:0] wr_data_in,
  output reg  [31:0] rd_data_out,
  input  wire        resume_detect_in,
  input  wire        resume_status_in,
  input  wire        int_event_in,
  input  wire        sof_in,
  input  wire        iso_found_in,
  input  wire        control_served_in,
  output reg         periodic_go_out,
  output reg         control_go_out,
  output reg         bulk_go_out,
  output wire        iso_halt_out,
  output wire        serve_control_out,
  output wire        bus_irq_out,
  output wire        smi_out,
  output wire        remote_wake_out,
  output wire        root_reset_out,
  output wire        sof_run_out,
  output wire [1:0]  functional_state_out
);
  reg        rst_meta;
  reg        rst_n;
  reg [1:0]  functional_state;
  reg [1:0]  control_bulk_ratio;
  reg        periodic_list_enable;
  reg        isochronous_enable;
  reg        control_list_enable;
  reg        bulk_list_enable;
  reg        interrupt_routing;
  reg        wakeup_connected;
  reg        wakeup_enable;
  reg        iso_go;
  reg [2:0]  ctrl_count;
  reg [1:0]  next_state;
  reg [1:0]  prev_state;
  wire       hit;
  wire       resume_sync;
  wire [1:0] wr_state;

  // reset release through two flops
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // resume signalling arrives from the port pins
  hoc_sync #(
    .WIDTH (1)
  ) u_resume_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .async_in (resume_detect_in),
    .sync_out (resume_sync)
  );

  assign hit      = (addr_in == `HOC_CTRL_OFFSET);
  assign wr_state = wr_data_in[`HOC_STATE_LSB+1:`HOC_STATE_LSB];

  // state field: software write, or suspend to resume
  always @* begin
    next_state = functional_state;
    if (wr_en_in && hit) begin
      next_state = wr_state;
    end else if (functional_state == `HOC_STATE_SUSPEND &&
                 resume_sync) begin
      next_state = `HOC_STATE_RESUME;
    end
  end

  // software-owned fields and state
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      functional_state     <= `HOC_STATE_RESET;
      control_bulk_ratio   <= 2'h0;
      periodic_list_enable <= 1'b0;
      isochronous_enable   <= 1'b0;
      control_list_enable  <= 1'b0;
      bulk_list_enable     <= 1'b0;
      interrupt_routing    <= 1'b0;
      wakeup_connected     <= 1'b0;
      wakeup_enable        <= 1'b0;
    end else if (soft_reset_in) begin
      // routing and connected kept
      functional_state     <= `HOC_STATE_SUSPEND;
      control_bulk_ratio   <= 2'h0;
      periodic_list_enable <= 1'b0;
      isochronous_enable   <= 1'b0;
      control_list_enable  <= 1'b0;
      bulk_list_enable     <= 1'b0;
      wakeup_enable        <= 1'b0;
    end else begin
      functional_state <= next_state;
      if (wr_en_in && hit) begin
        // only writes touch these fields
        control_bulk_ratio   <= wr_data_in[`HOC_RATIO_LSB+1:
                                           `HOC_RATIO_LSB];
        periodic_list_enable <= wr_data_in[`HOC_PERIODIC_BIT];
        isochronous_enable   <= wr_data_in[`HOC_ISO_BIT];
        control_list_enable  <= wr_data_in[`HOC_CONTROL_BIT];
        bulk_list_enable     <= wr_data_in[`HOC_BULK_BIT];
        interrupt_routing    <= wr_data_in[`HOC_ROUTING_BIT];
        wakeup_connected     <= wr_data_in[`HOC_CONNECTED_BIT];
        wakeup_enable        <= wr_data_in[`HOC_WAKE_BIT];
      end
    end
  end

  // read data, reserved bits as zero
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out <= `HOC_CTRL_RESET;
    end else if (rd_en_in && hit) begin
      rd_data_out <= {21'h000000, wakeup_enable, wakeup_connected,
                      interrupt_routing, functional_state,
                      bulk_list_enable, control_list_enable,
                      isochronous_enable, periodic_list_enable,
                      control_bulk_ratio};
    end else begin
      rd_data_out <= 32'h0000_0000;
    end
  end

  // list enables sampled at each frame start
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      periodic_go_out <= 1'b0;
      control_go_out  <= 1'b0;
      bulk_go_out     <= 1'b0;
      iso_go          <= 1'b0;
      prev_state      <= `HOC_STATE_RESET;
    end else begin
      prev_state <= functional_state;
      if (sof_in) begin
        periodic_go_out <= periodic_list_enable;
        control_go_out  <= control_list_enable;
        bulk_go_out     <= bulk_list_enable;
        iso_go          <= isochronous_enable;
      end
    end
  end

  // isochronous item with iso disabled ends periodic pass
  assign iso_halt_out = iso_found_in && !iso_go;

  // control-to-bulk counter, kept across frames
  // after ratio+1 control items one cycle is given to bulk, then restart
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_count <= 3'h0;
    end else if (ctrl_count > {1'b0, control_bulk_ratio}) begin
      ctrl_count <= 3'h0;
    end else if (control_served_in) begin
      ctrl_count <= ctrl_count + 3'h1;
    end
  end
  assign serve_control_out = (ctrl_count <= {1'b0, control_bulk_ratio});

  // frame start delay after entering operational
  hoc_sof_timer #(
    .DELAY_CYC (SOF_DELAY_CYC)
  ) u_sof_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .enter_in    (functional_state == `HOC_STATE_OPER &&
                  prev_state != `HOC_STATE_OPER),
    .oper_in     (functional_state == `HOC_STATE_OPER),
    .sof_run_out (sof_run_out)
  );

  // interrupt routing, independent of wake-up enable
  assign bus_irq_out = int_event_in && !interrupt_routing;
  assign smi_out     = int_event_in && interrupt_routing;
  assign remote_wake_out = wakeup_enable && resume_status_in;
  assign root_reset_out  = (functional_state == `HOC_STATE_RESET);
  assign functional_state_out = functional_state;
endmodule // hoc_control

// ---- src/hoc_map.vh ----
// register offsets, fields, reset values and timing for the control register
`ifndef HOC_MAP_VH
`define HOC_MAP_VH
`define HOC_CTRL_OFFSET     8'h04
`define HOC_CTRL_RESET      32'h0000_0000
`define HOC_CTRL_RW_MASK    32'h0000_07FF
`define HOC_RATIO_LSB       0
`define HOC_PERIODIC_BIT    2
`define HOC_ISO_BIT         3
`define HOC_CONTROL_BIT     4
`define HOC_BULK_BIT        5
`define HOC_STATE_LSB       6
`define HOC_ROUTING_BIT     8
`define HOC_CONNECTED_BIT   9
`define HOC_WAKE_BIT        10
`define HOC_STATE_RESET     2'h0
`define HOC_STATE_RESUME    2'h1
`define HOC_STATE_OPER      2'h2
`define HOC_STATE_SUSPEND   2'h3
`define HOC_SOF_DELAY_NS    1000000
`define HOC_CLK_PERIOD_NS   10
`define HOC_SOF_DELAY_CYC   (`HOC_SOF_DELAY_NS / `HOC_CLK_PERIOD_NS)
`endif

// ---- src/hoc_sof_timer.v ----
// counts the delay from entering operational to the first frame start
`timescale 1ns/1ns
module hoc_sof_timer #(
  parameter DELAY_CYC = 100000
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire enter_in,
  input  wire oper_in,
  output reg  sof_run_out
);
  reg [31:0] count;

  // restart on entry, abort when leaving operational
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count       <= 32'h0000_0000;
      sof_run_out <= 1'b0;
    end else if (!oper_in) begin
      count       <= 32'h0000_0000;
      sof_run_out <= 1'b0;
    end else if (enter_in) begin
      count       <= 32'h0000_0000;
      sof_run_out <= 1'b0;
    end else if (!sof_run_out) begin
      if (count == DELAY_CYC - 1) begin
        sof_run_out <= 1'b1;
      end else begin
        count <= count + 32'h0000_0001;
      end
    end
  end
endmodule // hoc_sof_timer

// ---- src/hoc_sync.v ----
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
module hoc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;

  // first stage is only read by the second
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // hoc_sync

// ---- test/hoc_control_checker.sv ----
// port assertions for the host operating control register
`timescale 1ns/1ns
module hoc_control_checker #(
  parameter SOF_DELAY_CYC = 20
) (
  input wire logic clk_in, rst_n_in, soft_reset_in, wr_en_in, rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] rd_data_out,
  input wire logic resume_status_in, int_event_in, sof_in, iso_found_in,
  input wire logic periodic_go_out, control_go_out, bulk_go_out,
  input wire logic iso_halt_out, bus_irq_out, smi_out, remote_wake_out,
  input wire logic root_reset_out, sof_run_out,
  input wire logic control_served_in, serve_control_out,
  input wire logic [1:0] functional_state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // read side and reserved bits
  reserved_zero_a: assert property (
    rd_data_out[31:11] == 21'h0) else $error("reserved bits read nonzero");
  unmapped_read_a: assert property (
    rd_en_in && addr_in != 8'h04 |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  // interrupt routing and wake-up
  wake_cause_a: assert property (
    remote_wake_out |-> resume_status_in) else $error("wake without status");
  irq_route_a: assert property (
    int_event_in |-> bus_irq_out ^ smi_out) else $error("irq misrouted");
  irq_cause_a: assert property (
    bus_irq_out || smi_out |-> int_event_in) else $error("irq without event");
  // functional state
  state_self_a: assert property (
    $changed(functional_state_out) && !$past(wr_en_in)
    && !$past(soft_reset_in) |-> $past(functional_state_out) == 2'h3
    && functional_state_out == 2'h1) else $error("bad state change");
  soft_suspend_a: assert property (
    soft_reset_in |=> functional_state_out == 2'h3)
    else $error("soft reset not suspend");
  root_reset_a: assert property (
    root_reset_out == (functional_state_out == 2'h0))
    else $error("root reset mismatch");
  sof_delay_a: assert property (
    $rose(functional_state_out == 2'h2) |-> !sof_run_out [*8]
    ##[1:30] sof_run_out) else $error("frame start timing wrong");
  // list enables move only at frame start
  go_latch_a: assert property (
    $changed({periodic_go_out, control_go_out, bulk_go_out})
    |-> $past(sof_in) || $past(soft_reset_in)) else $error("go off frame");
  iso_halt_a: assert property (
    iso_halt_out |-> iso_found_in) else $error("halt without iso");
  bulk_turn_a: assert property (
    !serve_control_out |=> serve_control_out)
    else $error("bulk turn not one cycle");
  cover property (remote_wake_out);
  cover property (smi_out);
  cover property ($rose(sof_run_out));
  cover property (iso_halt_out);
endmodule // hoc_control_checker
bind hoc_control hoc_control_checker #(
  .SOF_DELAY_CYC (SOF_DELAY_CYC)
) chk_i (
  .clk_in               (clk_in),
  .rst_n_in             (rst_n_in),
  .soft_reset_in        (soft_reset_in),
  .wr_en_in             (wr_en_in),
  .rd_en_in             (rd_en_in),
  .addr_in              (addr_in),
  .rd_data_out          (rd_data_out),
  .resume_status_in     (resume_status_in),
  .int_event_in         (int_event_in),
  .sof_in               (sof_in),
  .iso_found_in         (iso_found_in),
  .periodic_go_out      (periodic_go_out),
  .control_go_out       (control_go_out),
  .bulk_go_out          (bulk_go_out),
  .iso_halt_out         (iso_halt_out),
  .bus_irq_out          (bus_irq_out),
  .smi_out              (smi_out),
  .remote_wake_out      (remote_wake_out),
  .root_reset_out       (root_reset_out),
  .sof_run_out          (sof_run_out),
  .control_served_in    (control_served_in),
  .serve_control_out    (serve_control_out),
  .functional_state_out (functional_state_out)
);

// ---- test/tb.sv ----
// self-checking bench for the host operating control register
`timescale 1ns/1ns
module tb;
  logic clk_in = 0, rst_n_in = 0, soft_reset_in = 0, wr_en_in = 0;
  logic rd_en_in = 0, resume_detect_in = 0, resume_status_in = 0;
  logic int_event_in = 0, sof_in = 0, iso_found_in = 0;
  logic control_served_in = 0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0, rd_data_out;
  logic periodic_go_out, control_go_out, bulk_go_out, iso_halt_out;
  logic serve_control_out, bus_irq_out, smi_out, remote_wake_out;
  logic root_reset_out, sof_run_out;
  logic [1:0] functional_state_out;
  int fail_count = 0, checks_done = 0, n;
  hoc_control #(
    .SOF_DELAY_CYC (20)
  ) dut (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .soft_reset_in        (soft_reset_in),
    .wr_en_in             (wr_en_in),
    .rd_en_in             (rd_en_in),
    .addr_in              (addr_in),
    .wr_data_in           (wr_data_in),
    .rd_data_out          (rd_data_out),
    .resume_detect_in     (resume_detect_in),
    .resume_status_in     (resume_status_in),
    .int_event_in         (int_event_in),
    .sof_in               (sof_in),
    .iso_found_in         (iso_found_in),
    .control_served_in    (control_served_in),
    .periodic_go_out      (periodic_go_out),
    .control_go_out       (control_go_out),
    .bulk_go_out          (bulk_go_out),
    .iso_halt_out         (iso_halt_out),
    .serve_control_out    (serve_control_out),
    .bus_irq_out          (bus_irq_out),
    .smi_out              (smi_out),
    .remote_wake_out      (remote_wake_out),
    .root_reset_out       (root_reset_out),
    .sof_run_out          (sof_run_out),
    .functional_state_out (functional_state_out)
  );
  initial forever #5 clk_in = ~clk_in;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task hw_reset;
    rst_n_in <= 0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1;
    repeat (3) @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_en_in <= 1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    rd_en_in <= 1;
    addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 0;
    #1 chk(rd_data_out, exp);
  endtask
  task pulse_sof;
    @(posedge clk_in);
    sof_in <= 1;
    @(posedge clk_in);
    sof_in <= 0;
    #1;
  endtask
  task pulse_served;
    @(posedge clk_in);
    control_served_in <= 1;
    @(posedge clk_in);
    control_served_in <= 0;
    #1;
  endtask
  // main sequence
  initial begin
    hw_reset;
    rd(8'h04, 32'h0);
    chk({30'h0, root_reset_out, functional_state_out[0]}, 32'h2);
    wr(8'h04, 32'h0000_073F);
    wr(8'h08, 32'h0000_00FF);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0000_073F);
    $display("test reset and access done");
    @(posedge clk_in);
    int_event_in <= 1;
    resume_status_in <= 1;
    @(posedge clk_in);
    #1 chk({29'h0, bus_irq_out, smi_out, remote_wake_out}, 32'h3);
    wr(8'h04, 32'h0000_023F);
    chk({29'h0, bus_irq_out, smi_out, remote_wake_out}, 32'h4);
    wr(8'h04, 32'h0000_063F);
    chk({29'h0, bus_irq_out, smi_out, remote_wake_out}, 32'h5);
    $display("test routing done");
    chk({periodic_go_out, control_go_out, bulk_go_out}, 32'h0);
    pulse_sof;
    chk({periodic_go_out, control_go_out, bulk_go_out}, 32'h7);
    iso_found_in <= 1;
    wr(8'h04, 32'h0000_0200);
    chk({iso_halt_out, bulk_go_out}, 32'h1);
    pulse_sof;
    chk({iso_halt_out, periodic_go_out, bulk_go_out}, 32'h4);
    iso_found_in <= 0;
    wr(8'h04, 32'h0000_0201);
    chk({31'h0, serve_control_out}, 32'h1);
    pulse_served;
    chk({31'h0, serve_control_out}, 32'h1);
    pulse_served;
    chk({31'h0, serve_control_out}, 32'h0);
    @(posedge clk_in);
    #1 chk({31'h0, serve_control_out}, 32'h1);
    $display("test list enables done");
    wr(8'h04, 32'h0000_073F);
    soft_reset_in <= 1;
    @(posedge clk_in);
    soft_reset_in <= 0;
    rd(8'h04, 32'h0000_03C0);
    resume_detect_in <= 1;
    for (n = 0; n < 10 && functional_state_out !== 2'h1; n++) begin
      @(posedge clk_in);
      #1;
    end
    resume_detect_in <= 0;
    chk({30'h0, functional_state_out}, 32'h1);
    if (n == 10) conclude;
    $display("test soft reset and resume done");
    wr(8'h04, 32'h0000_0380);
    for (n = 0; n < 100 && sof_run_out !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    chk({31'h0, n >= 19 && n <= 21}, 32'h1);
    if (n == 100) conclude;
    wr(8'h04, 32'h0000_0200);
    repeat (2) @(posedge clk_in);
    #1 chk({30'h0, sof_run_out, root_reset_out}, 32'h1);
    hw_reset;
    rd(8'h04, 32'h0);
    $display("test frame start and hardware reset done");
    conclude;
  end
endmodule // tb
